//--- hdl/logic_block.sv
// one programmable logic block: macrocells, output routing, I/O cells, security
// assumes an Avalon-MM master with waitrequest on the system clock; pins are async
//
// Contract
// - D or T storage plus XOR emulates J-K and S-R; terms split between inputs.
// - D, T and latch types take the extra term on the XOR input; J-K and S-R take it as K or R.
// - every register type has a programmable data input polarity.
// - clock or latch enable polarity of each macrocell is programmable.
// - synchronous mode picks one of four block clocks; asynchronous adds a term clock.
// - synchronous mode offers reset and preset from shared block terms.
// - two-to-one blocks: half the macrocells drive I/O cells, eight by four choices.
// - one-to-one blocks: each macrocell may drive any one of eight I/O cells.
// - two-to-one routing groups follow the fixed macrocell to I/O cell table.
// - each I/O cell has its own enable term; pin feedback goes to input routing.
// - I/O cell stores the pin in a register or latch on any block clock.
// - I/O cell storage is independent and starts low at power-up.
// - four global clock pins feed a generator making four block clocks.
// - block clocks pair as true or complement of global clocks per table.
// - two-pin variants tie global clock two to zero and three to one.
// - security bit blocks readback, programming and verify; only erase clears it. Here the rst_n reset clears it as well.
// - synchronous or asynchronous mode changes only clocking and initialisation.
//
// The implementer's own choices: register access over Avalon-MM and the address map.
`timescale 1ns/1ps
module logic_block #(
  parameter int NUM_MC     = cell_pkg::NUM_MC_DEF,
  parameter int NUM_IO     = cell_pkg::NUM_IO_DEF,
  parameter bit ONE_TO_ONE = 1'b0
) (
  input  wire logic                   clock,              // 40 MHz system clock
  input  wire logic                   rst_n,              // async reset, active low
  input  wire cell_pkg::av_req_t      bus,                // Avalon-MM request
  output logic [cell_pkg::DATA_W-1:0] readdata,           // Avalon-MM read data
  output logic                        waitrequest,        // Avalon-MM stall
  input  wire logic                   global_clock_zero,  // global clock pin 0
  input  wire logic                   global_clock_one,   // global clock pin 1
  input  wire logic                   global_clock_two,   // global clock pin 2
  input  wire logic                   global_clock_three, // global clock pin 3
  input  wire logic [NUM_MC-1:0]      pt_data,            // main cluster sum per cell
  input  wire logic [NUM_MC-1:0]      pt_extra,           // extra term: XOR input, or K/R for J-K and S-R
  input  wire logic [NUM_MC-1:0]      pt_clock,           // individual clock term
  input  wire logic                   pt_reset,           // shared block reset term
  input  wire logic                   pt_preset,          // shared block preset term
  input  wire logic [NUM_IO-1:0]      pt_oe,              // output enable term per cell
  input  wire logic [NUM_IO-1:0]      pin_in,             // pin level seen at the pad
  output logic      [NUM_IO-1:0]      pin_out,            // pin drive value
  output logic      [NUM_IO-1:0]      pin_oe,             // pin driver enable
  output logic      [NUM_IO-1:0]      io_direct,          // unregistered pin feedback
  output logic      [NUM_IO-1:0]      io_registered,      // stored pin feedback
  output logic      [NUM_MC-1:0]      mc_out              // macrocell outputs
);

  // ==========================================================================
  // elaboration checks
  if (NUM_IO != cell_pkg::IO_GROUP || NUM_MC > (1 << cell_pkg::SRC_W)
      || NUM_MC != (ONE_TO_ONE ? NUM_IO : 2 * NUM_IO)) begin : g_bad_size
    $error("logic_block: unsupported macrocell or I/O cell count");
  end

  typedef struct packed {
    logic                                ack;
    logic [cell_pkg::DATA_W-1:0]         rdata;
    logic                                two_pin;
    logic                                secure;
    logic [3:0]                          clk_combo;
    cell_pkg::mc_cfg_t [NUM_MC-1:0]      mc_cfg;
    cell_pkg::io_cfg_t [NUM_IO-1:0]      io_cfg;
    logic [NUM_MC-1:0]                   q;
    logic [NUM_MC-1:0]                   mc_prev;
    logic [NUM_IO-1:0]                   io_q;
    logic [NUM_IO-1:0]                   io_prev;
    logic [3:0]                          gsync1;
    logic [3:0]                          gsync2;
    logic [NUM_IO-1:0]                   psync1;
    logic [NUM_IO-1:0]                   psync2;
  } state_t;

  state_t     st;
  state_t     next_st;
  logic [1:0] rst_pipe;
  logic       rst_q;
  logic [3:0] bclk;
  logic       wr_ack;
  logic       wr_ctrl;
  logic       pu;
  logic       mc_hit;
  logic       io_hit;
  logic       cfg_hit;
  int         mc_idx;
  int         io_idx;
  logic       h_rise;
  logic       h_eff;
  logic       h_val;

  // ==========================================================================
  // helpers
  function automatic logic route_ok(input int mc, input int io);
    int g;
    int off;
    g   = (mc / 2) % cell_pkg::ROUTE_GROUPS;
    off = (io + cell_pkg::IO_GROUP - ((g + cell_pkg::ROUTE_SKEW) % cell_pkg::IO_GROUP))
          % cell_pkg::IO_GROUP;
    if (mc >= NUM_MC)
      return 1'b0;
    if (ONE_TO_ONE)
      return (mc / cell_pkg::IO_GROUP) == (io / cell_pkg::IO_GROUP);
    return off < cell_pkg::ROUTE_CHOICES;
  endfunction

  // returns {toggle, value}; the extra term rides the XOR input for D, T and latch, K or R for J-K and S-R
  function automatic logic [1:0] cell_input(input cell_pkg::kind_t k, input logic q,
                                             input logic a, input logic b);
    case (k)
      cell_pkg::KIND_T:  cell_input = {1'b1, a ^ b};
      cell_pkg::KIND_JK: cell_input = {1'b1, (a & ~q) | (b & q)};
      cell_pkg::KIND_SR: cell_input = {1'b0, a | (~b & q)};
      default:           cell_input = {1'b0, a ^ b};
    endcase
  endfunction

  function automatic int cell_index(input logic [7:0] addr, input logic [7:0] base);
    return int'(8'(addr - base)) >> 2;
  endfunction

  // ==========================================================================
  // reset release and clock generator
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n)
      rst_pipe <= 2'b00;
    else
      rst_pipe <= {rst_pipe[0], 1'b1};
  end
  assign rst_q = rst_pipe[1];

  block_clock_gen u_clkgen (
    .global_clock (st.gsync2),
    .two_pin      (st.two_pin),
    .combo        (st.clk_combo),
    .block_clock  (bclk)
  );

  // ==========================================================================
  // bus decode
  assign mc_idx      = cell_index(bus.address, cell_pkg::REG_MC_CFG_BASE);
  assign io_idx      = cell_index(bus.address, cell_pkg::REG_IO_CFG_BASE);
  assign mc_hit      = bus.address >= cell_pkg::REG_MC_CFG_BASE && mc_idx < NUM_MC;
  assign io_hit      = bus.address >= cell_pkg::REG_IO_CFG_BASE && io_idx < NUM_IO;
  assign cfg_hit     = mc_hit || io_hit || bus.address == cell_pkg::REG_CLKGEN;
  assign wr_ack      = bus.write && st.ack;
  assign wr_ctrl     = wr_ack && bus.address == cell_pkg::REG_CTRL;
  assign pu          = wr_ctrl && bus.writedata[cell_pkg::CTRL_POWERUP];
  // every access is answered on the second cycle
  assign waitrequest = (bus.read || bus.write) && !st.ack;
  assign readdata    = st.rdata;

  // ==========================================================================
  // next state
  always_comb begin
    cell_pkg::mc_cfg_t cfg;
    cell_pkg::io_cfg_t ic;
    logic [1:0]        tv;
    logic              a;
    logic              eff;
    logic              ok;
    cfg     = '0;
    ic      = '0;
    tv      = 2'b00;
    a       = 1'b0;
    eff     = 1'b0;
    ok      = 1'b0;
    h_rise  = 1'b0;
    h_eff   = 1'b0;
    h_val   = 1'b0;
    next_st = st;
    next_st.gsync1 = {global_clock_three, global_clock_two, global_clock_one,
                      global_clock_zero};
    next_st.gsync2 = st.gsync1;
    next_st.psync1 = pin_in;
    next_st.psync2 = st.psync1;
    next_st.ack    = (bus.read || bus.write) && !st.ack;

    // macrocells; logic function is the same in either mode
    for (int i = 0; i < NUM_MC; i++) begin
      cfg = st.mc_cfg[i];
      a   = pt_data[i] ^ cfg.in_pol;
      tv  = cell_input(cfg.kind, st.q[i], a, pt_extra[i]);
      if (cfg.async_mode && cfg.clk_sel == cell_pkg::CLK_SEL_TERM)
        eff = pt_clock[i] ^ cfg.clk_pol;
      else
        eff = bclk[cfg.clk_sel[1:0]] ^ cfg.clk_pol;
      next_st.mc_prev[i] = eff;
      if (cfg.kind == cell_pkg::KIND_LATCH) begin
        if (!eff)
          next_st.q[i] = tv[0];
      end else if (eff && !st.mc_prev[i]) begin
        next_st.q[i] = tv[1] ? st.q[i] ^ tv[0] : tv[0];
      end
      // emulated asynchronous init, synchronous mode only; reset beats preset
      if (!cfg.async_mode) begin
        if (cfg.init == cell_pkg::INIT_SET && pt_preset)
          next_st.q[i] = 1'b1;
        if (cfg.init == cell_pkg::INIT_RESET && pt_reset)
          next_st.q[i] = 1'b0;
      end
      mc_out[i] = cfg.comb ? tv[0] : st.q[i];
      if (i == 0) begin
        h_rise = eff && !st.mc_prev[i];
        h_eff  = eff;
        h_val  = tv[0];
      end
    end

    // I/O cells
    for (int j = 0; j < NUM_IO; j++) begin
      ic         = st.io_cfg[j];
      ok         = route_ok(int'(ic.src), j);
      pin_out[j] = ok ? mc_out[ic.src] : 1'b0;
      pin_oe[j]  = ok && ic.drive && pt_oe[j];
      eff        = bclk[ic.clk_sel] ^ ic.clk_pol;
      next_st.io_prev[j] = eff;
      if (ic.in_latch) begin
        if (!eff)
          next_st.io_q[j] = st.psync2[j];
      end else if (eff && !st.io_prev[j]) begin
        next_st.io_q[j] = st.psync2[j];
      end
    end
    io_direct     = st.psync2;
    io_registered = st.io_q;

    // register reads, captured while waitrequest is high
    if (bus.read && !st.ack) begin
      next_st.rdata = cell_pkg::READ_UNMAPPED;
      if (bus.address == cell_pkg::REG_CTRL)
        next_st.rdata = 32'({st.secure, st.two_pin});
      else if (bus.address == cell_pkg::REG_MC_STATE)
        next_st.rdata = 32'(st.q);
      else if (bus.address == cell_pkg::REG_IO_STATE)
        next_st.rdata = 32'({st.psync2, st.io_q});
      else if (st.secure)
        next_st.rdata = cell_pkg::READ_UNMAPPED;
      else if (bus.address == cell_pkg::REG_CLKGEN)
        next_st.rdata = 32'(st.clk_combo);
      else if (mc_hit)
        next_st.rdata = 32'(st.mc_cfg[mc_idx]);
      else if (io_hit)
        next_st.rdata = 32'(st.io_cfg[io_idx]);
    end

    // register writes, taking effect at the edge where waitrequest is low
    if (wr_ack && !st.secure) begin
      if (bus.address == cell_pkg::REG_CLKGEN)
        next_st.clk_combo = bus.writedata[3:0];
      else if (mc_hit)
        next_st.mc_cfg[mc_idx] = cell_pkg::mc_cfg_t'(bus.writedata[cell_pkg::MC_CFG_W-1:0]);
      else if (io_hit)
        next_st.io_cfg[io_idx] = cell_pkg::io_cfg_t'(bus.writedata[cell_pkg::IO_CFG_W-1:0]);
      else if (wr_ctrl)
        next_st.two_pin = bus.writedata[cell_pkg::CTRL_TWO_PIN];
    end
    if (wr_ctrl && bus.writedata[cell_pkg::CTRL_SECURE])
      next_st.secure = 1'b1;
    // erase and the rst_n reset are the only ways back out of the secured state
    if (wr_ctrl && bus.writedata[cell_pkg::CTRL_ERASE]) begin
      next_st.secure    = 1'b0;
      next_st.two_pin   = 1'b0;
      next_st.clk_combo = 4'h0;
      next_st.mc_cfg    = '0;
      next_st.io_cfg    = '0;
    end
    // power-up load uses the configuration in force before this write
    if (pu) begin
      for (int i = 0; i < NUM_MC; i++)
        next_st.q[i] = st.mc_cfg[i].init == cell_pkg::INIT_SET;
      next_st.io_q = '0;
    end
  end

  always_ff @(posedge clock or negedge rst_q) begin
    if (!rst_q)
      st <= '0;
    else
      st <= next_st;
  end

  // ==========================================================================
  // checks
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!rst_q);

  chk_secure_readback: assert property (
    (bus.read && !waitrequest && st.secure && cfg_hit) |-> readdata == 32'h0)
    else $error("configuration readable while secured");

  chk_secure_lock: assert property (
    (wr_ack && st.secure && bus.address == cell_pkg::REG_CLKGEN && !pu)
      |=> $stable(st.clk_combo) && st.secure)
    else $error("configuration changed while secured");

  chk_erase_clears: assert property (
    (wr_ctrl && bus.writedata[cell_pkg::CTRL_ERASE])
      |=> !st.secure && st.clk_combo == 4'h0 && st.mc_cfg == '0)
    else $error("erase left configuration or security behind");

  chk_d_load: assert property (
    (h_rise && st.mc_cfg[0].kind == cell_pkg::KIND_D
      && st.mc_cfg[0].init == cell_pkg::INIT_NONE && !pu) |=> st.q[0] == $past(h_val))
    else $error("D register did not load on its edge");

  chk_t_toggle: assert property (
    (h_rise && st.mc_cfg[0].kind == cell_pkg::KIND_T && h_val
      && st.mc_cfg[0].init == cell_pkg::INIT_NONE && !pu) |=> st.q[0] != $past(st.q[0]))
    else $error("T register did not toggle");

  chk_latch_pass: assert property (
    (st.mc_cfg[0].kind == cell_pkg::KIND_LATCH && !h_eff
      && st.mc_cfg[0].init == cell_pkg::INIT_NONE && !pu) |=> st.q[0] == $past(h_val))
    else $error("open latch did not pass its input");

  chk_sync_reset: assert property (
    (!st.mc_cfg[0].async_mode && st.mc_cfg[0].init == cell_pkg::INIT_RESET
      && pt_reset && !pu) |=> !st.q[0])
    else $error("shared reset term did not clear the cell");

  chk_powerup_init: assert property (
    pu |=> st.io_q == '0 && st.q[0] == ($past(st.mc_cfg[0].init) == cell_pkg::INIT_SET))
    else $error("power-up values wrong");

  chk_route_gate: assert property (
    pin_oe[0] |-> pt_oe[0] && st.io_cfg[0].drive && route_ok(int'(st.io_cfg[0].src), 0))
    else $error("pin driven without enable term or legal route");

  chk_clock_tie: assert property (
    (st.two_pin && st.clk_combo == 4'h0) |-> bclk[2] == bclk[0] && bclk[3] == bclk[1])
    else $error("two-pin tie of global clocks broken");

  cov_secure:  cover property (wr_ctrl && bus.writedata[cell_pkg::CTRL_SECURE]);
  cov_jk_edge: cover property (h_rise && st.mc_cfg[0].kind == cell_pkg::KIND_JK);
  cov_drive:   cover property (pin_oe[0] ##1 !pin_oe[0]);
  cov_powerup: cover property (pu);

endmodule

//--- hdl/cell_pkg.sv
// constants, register map and carrier types for the programmable logic block
// assumes one 40 MHz system clock; all block clocks are emulated as sampled levels
package cell_pkg;

  // ==========================================================================
  // bus and register map (byte addresses, one 32-bit word each)
  localparam int          ADDR_W           = 8;
  localparam int          DATA_W           = 32;
  localparam logic [7:0]  REG_CTRL         = 8'h00;
  localparam logic [7:0]  REG_CLKGEN       = 8'h04;
  localparam logic [7:0]  REG_MC_STATE     = 8'h08;
  localparam logic [7:0]  REG_IO_STATE     = 8'h0c;
  localparam logic [7:0]  REG_MC_CFG_BASE  = 8'h40;
  localparam logic [7:0]  REG_IO_CFG_BASE  = 8'h80;
  localparam logic [31:0] READ_UNMAPPED    = 32'h0000_0000;

  // control register bit positions
  localparam int CTRL_TWO_PIN = 0;
  localparam int CTRL_SECURE  = 1;
  localparam int CTRL_ERASE   = 2;
  localparam int CTRL_POWERUP = 3;

  // ==========================================================================
  // block geometry
  localparam int NUM_MC_DEF    = 16;
  localparam int NUM_IO_DEF    = 8;
  localparam int BLOCK_CLOCKS  = 4;
  localparam int IO_GROUP      = 8;
  localparam int ROUTE_CHOICES = 4;
  localparam int ROUTE_GROUPS  = 6;
  localparam int ROUTE_SKEW    = 5;
  localparam int SRC_W         = 4;

  // ==========================================================================
  // configuration encodings
  typedef enum logic [2:0] {
    KIND_D     = 3'b000,
    KIND_T     = 3'b001,
    KIND_JK    = 3'b010,
    KIND_SR    = 3'b011,
    KIND_LATCH = 3'b100
  } kind_t;

  typedef enum logic [1:0] {
    INIT_NONE  = 2'b00,
    INIT_RESET = 2'b01,
    INIT_SET   = 2'b10
  } init_t;

  typedef enum logic [1:0] {
    COMBO_STRAIGHT = 2'b00,
    COMBO_HI_BOTH  = 2'b01,
    COMBO_LO_BOTH  = 2'b10,
    COMBO_CROSSED  = 2'b11
  } combo_t;

  localparam logic [2:0] CLK_SEL_TERM = 3'h4;

  typedef struct packed {
    logic        comb;
    init_t       init;
    logic        in_pol;
    logic        clk_pol;
    logic [2:0]  clk_sel;
    logic        async_mode;
    kind_t       kind;
  } mc_cfg_t;

  typedef struct packed {
    logic             clk_pol;
    logic [1:0]       clk_sel;
    logic             in_latch;
    logic             drive;
    logic [SRC_W-1:0] src;
  } io_cfg_t;

  localparam int MC_CFG_W = $bits(mc_cfg_t);
  localparam int IO_CFG_W = $bits(io_cfg_t);

  typedef struct packed {
    logic              read;
    logic              write;
    logic [ADDR_W-1:0] address;
    logic [DATA_W-1:0] writedata;
  } av_req_t;

endpackage

//--- hdl/block_clock_gen.sv
// per-block clock generator: four block clocks from the four global clock levels
// assumes its global clock inputs are already synchronised to the system clock
`timescale 1ns/1ps
module block_clock_gen (
  input  wire logic       [3:0] global_clock,  // synchronised global clock levels
  input  wire logic             two_pin,       // only two global pins bonded
  input  wire logic       [3:0] combo,         // pairing choice, low pair then high pair
  output logic            [3:0] block_clock    // block clocks 0..3
);

  // ==========================================================================
  // pairing selection, returns {upper, lower}
  function automatic logic [1:0] pair(input logic [1:0] sel, input logic ga, input logic gb);
    case (cell_pkg::combo_t'(sel))
      cell_pkg::COMBO_STRAIGHT: pair = {gb, ga};
      cell_pkg::COMBO_HI_BOTH:  pair = {gb, ~gb};
      cell_pkg::COMBO_LO_BOTH:  pair = {~ga, ga};
      cell_pkg::COMBO_CROSSED:  pair = {~ga, ~gb};
      default:                  pair = {gb, ga};
    endcase
  endfunction

  logic g2;
  logic g3;

  always_comb begin
    g2 = two_pin ? global_clock[0] : global_clock[2];
    g3 = two_pin ? global_clock[1] : global_clock[3];
    block_clock[1:0] = pair(combo[1:0], global_clock[0], global_clock[1]);
    block_clock[3:2] = pair(combo[3:2], g2, g3);
  end

endmodule

//--- verification/pin_side.sv
// far-side model: pads with pull-ups and the four global clock pins
// assumes the bench raises live only once the reset delay is over
`timescale 1ns/1ps
module pin_side (
  input  wire logic       clock,   // system clock
  input  wire logic       live,    // reset delay over
  input  wire logic [3:0] kick,    // wanted clock levels
  input  wire logic [7:0] pin_out, // block drive value
  input  wire logic [7:0] pin_oe,  // block drive enable
  input  wire logic [7:0] drv_val, // pad value from outside
  input  wire logic [7:0] drv_en,  // outside drives the pad
  output logic      [3:0] glob,    // global clock pins
  output logic      [7:0] pin_in   // resolved pad level
);
  // ==========================================================================
  // clock pins stay quiet until released
  always_ff @(posedge clock) begin
    glob <= live ? kick : 4'h0;
  end
  // ==========================================================================
  // released pads float to the pull-up, never to the last value
  always_comb begin
    for (int i = 0; i < 8; i++) begin
      pin_in[i] = pin_oe[i] ? pin_out[i] : (drv_en[i] ? drv_val[i] : 1'b1);
    end
  end
endmodule

//--- verification/logic_block_test.sv
// self-checking bench for one logic block: bus, storage, routing, I/O cells
// assumes cell_pkg, the block and pin_side are compiled before it
`timescale 1ns/1ps
module logic_block_test;
  // ==========================================================================
  // signals
  logic              clock;
  logic              rst_n;
  cell_pkg::av_req_t bus;
  logic [31:0]       readdata;
  logic              waitrequest;
  logic              live;
  logic [3:0]        kick;
  logic [3:0]        glob;
  logic [15:0]       pt_data;
  logic [15:0]       pt_extra;
  logic [15:0]       mc_out;
  logic              pt_reset;
  logic [15:0]       pt_clock;
  logic              pt_preset;
  logic [7:0]        pt_oe;
  logic [7:0]        pin_in;
  logic [7:0]        pin_out;
  logic [7:0]        pin_oe;
  logic [7:0]        io_direct;
  logic [7:0]        io_registered;
  logic [7:0]        drv_val;
  logic [7:0]        drv_en;
  logic [31:0]       rd;
  int                n_mismatch;
  int                checks;
  int                cycles;
  localparam int first_io [6] = '{5, 6, 7, 0, 1, 2};

  logic_block DUT (.clock(clock), .rst_n(rst_n), .bus(bus), .readdata(readdata),
    .waitrequest(waitrequest), .global_clock_zero(glob[0]), .global_clock_one(glob[1]),
    .global_clock_two(glob[2]), .global_clock_three(glob[3]), .pt_data(pt_data),
    .pt_extra(pt_extra), .pt_clock(pt_clock), .pt_reset(pt_reset), .pt_preset(pt_preset),
    .pt_oe(pt_oe), .pin_in(pin_in), .pin_out(pin_out), .pin_oe(pin_oe),
    .io_direct(io_direct), .io_registered(io_registered), .mc_out(mc_out));
  pin_side far (.clock(clock), .live(live), .kick(kick), .pin_out(pin_out),
    .pin_oe(pin_oe), .drv_val(drv_val), .drv_en(drv_en), .glob(glob), .pin_in(pin_in));

  // ==========================================================================
  // shared tasks
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // request held until waitrequest is sampled low, then released
  task automatic access(input logic wr, input logic [7:0] a, input logic [31:0] d);
    bus <= '{read: !wr, write: wr, address: a, writedata: d};
    do begin
      @(posedge clock);
    end while (waitrequest !== 1'b0);
    rd = readdata;
    bus <= '0;
    @(posedge clock);
  endtask

  // long enough for the two-flop synchroniser plus the storage edge
  task automatic pulse(input logic [3:0] k);
    kick <= k;
    repeat (5) @(posedge clock);
    kick <= 4'h0;
    repeat (6) @(posedge clock);
  endtask

  task automatic close_out();
    $display("counts: %0d checks, %0d mismatches", checks, n_mismatch);
    if (n_mismatch == 0 && checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask

  // ==========================================================================
  // scenarios
  task automatic test_regs();
    check("io storage at reset", 32'(io_registered), 32'h0);
    access(1'b0, cell_pkg::REG_CTRL, 32'h0);
    check("ctrl reset", rd, 32'h0);
    access(1'b1, 8'hfc, 32'hffff_ffff);
    access(1'b0, 8'hfc, 32'h0);
    check("unmapped read", rd, cell_pkg::READ_UNMAPPED);
    $display("test regs done");
  endtask

  task automatic test_storage();
    pt_data <= 16'h000f;
    pt_extra <= 16'h0004;
    for (int i = 0; i < 4; i++) access(1'b1, cell_pkg::REG_MC_CFG_BASE + 8'(4 * i), 32'(i));
    pulse(4'h1);
    check("storage first", 32'(mc_out[3:0]), 32'hf);
    pulse(4'h1);
    check("storage second", 32'(mc_out[3:0]), 32'h9);
    access(1'b1, cell_pkg::REG_MC_CFG_BASE, 32'h100);
    pulse(4'h1);
    check("input polarity", 32'(mc_out[3:0]), 32'he);
    $display("test storage done");
  endtask

  task automatic test_clocks();
    access(1'b1, 8'h54, 32'h020);
    pt_data <= 16'h002f;
    pulse(4'h1);
    check("block clock two idle", 32'(mc_out[5]), 32'h0);
    access(1'b1, cell_pkg::REG_CTRL, 32'h1);
    pulse(4'h1);
    check("two pin tie", 32'(mc_out[5]), 32'h1);
    access(1'b1, cell_pkg::REG_CLKGEN, 32'h4);
    pt_data <= 16'h000f;
    pulse(4'h1);
    check("block clock two off pin zero", 32'(mc_out[5]), 32'h1);
    pulse(4'h2);
    check("complement pairing", 32'(mc_out[5]), 32'h0);
    $display("test clocks done");
  endtask

  task automatic test_powerup();
    access(1'b1, 8'h50, 32'h200);
    access(1'b1, 8'h58, 32'h400);
    access(1'b1, cell_pkg::REG_CTRL, 32'h8);
    access(1'b0, cell_pkg::REG_MC_STATE, 32'h0);
    check("powerup state", rd, 32'h40);
    pt_data <= 16'h0010;
    pulse(4'h1);
    check("load before reset", 32'(mc_out[4]), 32'h1);
    pt_reset <= 1'b1;
    repeat (3) @(posedge clock);
    check("shared reset", 32'(mc_out[4]), 32'h0);
    pt_reset <= 1'b0;
    $display("test powerup done");
  endtask

  task automatic test_routing();
    pt_oe <= 8'hff;
    for (int j = 0; j < 8; j++) begin
      for (int m = 0; m < 16; m++) begin
        access(1'b1, cell_pkg::REG_IO_CFG_BASE + 8'(4 * j), 32'h10 | 32'(m));
        check("route", 32'(pin_oe[j]), 32'(((j - first_io[(m / 2) % 6]) & 7) < 4));
      end
    end
    pt_oe <= 8'h00;
    repeat (2) @(posedge clock);
    check("enable term off", 32'(pin_oe), 32'h0);
    $display("test routing done");
  endtask

  task automatic test_io();
    drv_en <= 8'h02;
    drv_val <= 8'h00;
    pulse(4'h1);
    check("io store low", 32'(io_registered[1]), 32'h0);
    drv_val <= 8'h02;
    repeat (4) @(posedge clock);
    check("pin feedback", 32'(io_direct[1]), 32'h1);
    check("io holds", 32'(io_registered[1]), 32'h0);
    pulse(4'h1);
    check("io store high", 32'(io_registered[1]), 32'h1);
    $display("test io done");
  endtask

  task automatic test_modes();
    access(1'b1, cell_pkg::REG_MC_CFG_BASE, 32'h4);
    pt_data <= 16'h0000;
    repeat (2) @(posedge clock);
    check("latch open", 32'(mc_out[0]), 32'h0);
    kick <= 4'h1;
    repeat (4) @(posedge clock);
    pt_data <= 16'h0001;
    repeat (2) @(posedge clock);
    check("latch holds", 32'(mc_out[0]), 32'h0);
    kick <= 4'h0;
    repeat (5) @(posedge clock);
    check("latch reopens", 32'(mc_out[0]), 32'h1);
    access(1'b1, cell_pkg::REG_MC_CFG_BASE, 32'h1);
    pulse(4'h1);
    check("T toggles", 32'(mc_out[0]), 32'h0);
    access(1'b1, cell_pkg::REG_MC_CFG_BASE, 32'h201);
    pulse(4'h1);
    check("T toggles back", 32'(mc_out[0]), 32'h1);
    pt_reset <= 1'b1;
    repeat (2) @(posedge clock);
    check("reset term", 32'(mc_out[0]), 32'h0);
    pt_reset <= 1'b0;
    access(1'b1, cell_pkg::REG_MC_CFG_BASE, 32'h401);
    pt_preset <= 1'b1;
    repeat (2) @(posedge clock);
    check("preset term", 32'(mc_out[0]), 32'h1);
    pt_preset <= 1'b0;
    access(1'b1, cell_pkg::REG_IO_CFG_BASE, 32'h10);
    check("routed drive", 32'(pin_out[0]), 32'h1);
    pt_data <= 16'h0000;
    pt_clock <= 16'h0001;
    access(1'b1, cell_pkg::REG_MC_CFG_BASE, 32'hc8);
    pt_clock <= 16'h0000;
    repeat (2) @(posedge clock);
    check("term clock", 32'(mc_out[0]), 32'h0);
    $display("test modes done");
  endtask

  task automatic test_security();
    access(1'b1, 8'h5c, 32'h123);
    access(1'b0, 8'h5c, 32'h0);
    check("config readback", rd, 32'h123);
    access(1'b1, cell_pkg::REG_CTRL, 32'h2);
    access(1'b1, cell_pkg::REG_CLKGEN, 32'hf);
    access(1'b0, 8'h5c, 32'h0);
    check("secured readback", rd, 32'h0);
    access(1'b0, cell_pkg::REG_CTRL, 32'h0);
    check("secure bit", rd, 32'h2);
    access(1'b1, cell_pkg::REG_CTRL, 32'h4);
    access(1'b0, cell_pkg::REG_CTRL, 32'h0);
    check("erase clears", rd, 32'h0);
    access(1'b0, 8'h5c, 32'h0);
    check("erased config", rd, 32'h0);
    $display("test security done");
  endtask

  // ==========================================================================
  // clock, timeout and main sequence
  initial begin
    clock = 1'b0;
    forever #12.5 clock = ~clock;
  end

  always @(posedge clock) begin
    cycles++;
    if (cycles == 20000) begin
      n_mismatch++;
      close_out();
    end
  end

  initial begin
    rst_n = 1'b0;
    bus = '0;
    live = 1'b0;
    kick = 4'h0;
    pt_data = 16'h0;
    pt_extra = 16'h0;
    pt_reset = 1'b0;
    pt_clock = 16'h0;
    pt_preset = 1'b0;
    pt_oe = 8'h0;
    drv_val = 8'h0;
    drv_en = 8'h0;
    repeat (10) @(posedge clock);
    rst_n <= 1'b1;
    repeat (3) @(posedge clock);
    live <= 1'b1;
    test_regs();
    test_storage();
    test_clocks();
    test_powerup();
    test_routing();
    test_io();
    test_modes();
    test_security();
    close_out();
  end
endmodule
